/* design/mpc_map.svh */
// offsets, field positions, reset values and timing counts of the coordinator
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MPC_CTRL_OFS      8'h00
`define MPC_TRACK_OFS     8'h04
`define MPC_FAULT_OFS     8'h08
`define MPC_SHARE_OFS     8'h0c
`define MPC_FREQ_OFS      8'h10
`define MPC_PHASE_OFS     8'h14
`define MPC_DELAY_OFS     8'h18
`define MPC_STATUS_OFS    8'h1c
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MPC_TRK_EN_BIT    0
`define MPC_TRK_HALF_BIT  1
`define MPC_TRK_FOLLOW_BIT 2
`define MPC_FLT_SHUT_BIT  0
`define MPC_FLT_TX_BIT    1
`define MPC_FLT_RX_BIT    2
`define MPC_FLT_RST_BIT   3
`define MPC_SH_EN_BIT     0
`define MPC_SH_QR_BIT     1
`define MPC_CTL_DE_BIT    0
`define MPC_CTL_AFC_BIT   1
`define MPC_CTL_RCMP_BIT  2
`define MPC_PH_OVR_BIT    8
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MPC_CTRL_RST      32'h0000_0004
`define MPC_TRACK_RST     32'h0000_0000
`define MPC_FAULT_RST     32'h0000_0001
`define MPC_SHARE_RST     32'h0000_0000
`define MPC_FREQ_RST      16'h0014
`define MPC_PHASE_RST     32'h0000_0000
`define MPC_DELAY_RST     32'h0000_0000
// ----------------------------------------------------------------
// timing, message kinds and phase step
// ----------------------------------------------------------------
`define MPC_CLK_MHZ       10
`define MPC_PRE_RAMP_MS   5
`define MPC_PRE_RAMP_CYC  (`MPC_PRE_RAMP_MS * 1000 * `MPC_CLK_MHZ)
`define MPC_SYNC_TMO      16'h0100
`define MPC_MSG_FAULT     2'h1
`define MPC_MSG_SHARE     2'h2
`define MPC_PHASE_STEP    9'h02d
`endif

/* design/mpc_pkg.sv */
// types shared by the coordinator
package mpc_pkg;
   // bus message between peers
   typedef struct packed {
      logic       valid;
      logic [1:0] kind;
      logic [6:0] addr;
      logic [11:0] data;
   } mpc_msg_s;
   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mpc_req_s;
   typedef enum logic [5:0] {
      MPC_OFF   = 6'h01,
      MPC_DELAY = 6'h02,
      MPC_RAMP  = 6'h04,
      MPC_REG   = 6'h08,
      MPC_STOP  = 6'h10,
      MPC_FAULT = 6'h20
   } mpc_state_e;
endpackage

/* design/mpc_coord.sv */
// power coordination logic of one module on the shared peer bus
//
// Notes on behaviour
// - tracking follows reference at 50 or 100 percent
// - settled reference: follow perturbations or hold
// - after enable falls, keep tracking for turn-off delay
// - at enable, detect sync clock and lock
// - lost sync: fall back to last seen frequency
// - no sync at start: use configured frequency
// - recompensate on reaching regulation, configurable
// - adaptive frequency only in diode emulation, gated
// - shared enable edges start sequenced on and off
// - fault with shutdown response: stop and broadcast
// - received fault: stop, then restart in order
// - lowest sharing address becomes reference
// - reference broadcasts current, members adjust
// - quasi-redundant: failing member leaves others running
// - rail failure broadcast once whole rail failed
// - reference lost: next lowest address takes over
// - member count change redistributes phases
// - faulted rail restarts all members together
// - phase offset is address times 45 degrees, rank times 45 when sharing
// - wait about 5ms plus extra before ramping
`timescale 1ns/1ns
`include "mpc_map.svh"
module mpc_coord #(
   parameter int unsigned PRE_RAMP_CYC = `MPC_PRE_RAMP_CYC,
   parameter int unsigned RAMP_STEP    = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire mpc_pkg::mpc_req_s req,
   output      logic [31:0]      rdata,
   input  wire logic             enable_in,
   input  wire logic             sync_in,
   input  wire logic [6:0]       my_addr,
   input  wire logic [11:0]      tracking_reference_input,
   input  wire logic [11:0]      target_level,
   input  wire logic [11:0]      my_current,
   input  wire logic             local_fault,
   input  wire logic             pred_done,
   input  wire mpc_pkg::mpc_msg_s bus_rx,
   output mpc_pkg::mpc_msg_s     bus_tx,
   output      logic [11:0]      out_level,
   output      logic             out_on,
   output      logic             sync_locked,
   output      logic [15:0]      sw_period,
   output      logic [8:0]       phase_deg,
   output      logic             recomp_pulse,
   output      logic             afc_active,
   output      logic             is_reference,
   output      logic [11:0]      share_ref
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl, track, fault_cfg, share_cfg, phase_cfg, delay_cfg;
   logic [15:0] freq_cfg;
   mpc_pkg::mpc_state_e state;
   logic [31:0] tmr;
   logic        en_q, rx_fault, flt_hold;
   logic [15:0] sync_cnt, sync_last, sync_gap;
   logic        sync_q, sync_ok;
   logic [6:0]  low_seen;
   logic [7:0]  alive, failed;
   logic [2:0]  rank;
   logic [3:0]  members_q;
   logic        rail_sent, settled;

   // unpacking the shared fields
   wire trk_en   = track[`MPC_TRK_EN_BIT];
   wire trk_half = track[`MPC_TRK_HALF_BIT];
   wire trk_fol  = track[`MPC_TRK_FOLLOW_BIT];
   wire f_shut   = fault_cfg[`MPC_FLT_SHUT_BIT];
   wire f_tx     = fault_cfg[`MPC_FLT_TX_BIT];
   wire f_rx     = fault_cfg[`MPC_FLT_RX_BIT];
   wire f_rst    = fault_cfg[`MPC_FLT_RST_BIT];
   wire sh_en    = share_cfg[`MPC_SH_EN_BIT];
   wire sh_qr    = share_cfg[`MPC_SH_QR_BIT];

   // popcount of a peer vector
   function automatic logic [3:0] count8(input logic [7:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 8; i++) begin
         c = c + {3'h0, v[i]};
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   wire wr_ctrl  = req.wr && req.addr == `MPC_CTRL_OFS;
   wire wr_track = req.wr && req.addr == `MPC_TRACK_OFS;
   wire wr_fault = req.wr && req.addr == `MPC_FAULT_OFS;
   wire wr_share = req.wr && req.addr == `MPC_SHARE_OFS;
   wire wr_freq  = req.wr && req.addr == `MPC_FREQ_OFS;
   wire wr_phase = req.wr && req.addr == `MPC_PHASE_OFS;
   wire wr_delay = req.wr && req.addr == `MPC_DELAY_OFS;
   wire [31:0] status = {4'h0, members_q, 3'h0, rank, sync_ok,
                         is_reference, rx_fault, 9'h000, state};
   wire [31:0] next_rdata =
      !req.rd                         ? 32'h0000_0000 :
      req.addr == `MPC_CTRL_OFS       ? ctrl :
      req.addr == `MPC_TRACK_OFS      ? track :
      req.addr == `MPC_FAULT_OFS      ? fault_cfg :
      req.addr == `MPC_SHARE_OFS      ? share_cfg :
      req.addr == `MPC_FREQ_OFS       ? {16'h0000, freq_cfg} :
      req.addr == `MPC_PHASE_OFS      ? phase_cfg :
      req.addr == `MPC_DELAY_OFS      ? delay_cfg :
      req.addr == `MPC_STATUS_OFS     ? status : 32'h0000_0000;

   // register write and read data
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl      <= `MPC_CTRL_RST;
         track     <= `MPC_TRACK_RST;
         fault_cfg <= `MPC_FAULT_RST;
         share_cfg <= `MPC_SHARE_RST;
         freq_cfg  <= `MPC_FREQ_RST;
         phase_cfg <= `MPC_PHASE_RST;
         delay_cfg <= `MPC_DELAY_RST;
         rdata     <= 32'h0000_0000;
      end else if (ce) begin
         if (wr_ctrl)  ctrl      <= req.wdata;
         if (wr_track) track     <= req.wdata;
         if (wr_fault) fault_cfg <= req.wdata;
         if (wr_share) share_cfg <= req.wdata;
         if (wr_freq)  freq_cfg  <= req.wdata[15:0];
         if (wr_phase) phase_cfg <= req.wdata;
         if (wr_delay) delay_cfg <= req.wdata;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // sync detection
   // ----------------------------------------------------------------
   wire sync_rise = sync_in && !sync_q;
   wire en_rise   = enable_in && !en_q;
   wire sync_lost = sync_gap >= `MPC_SYNC_TMO;
   // measure period between rising sync edges, drop lock on timeout
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync_q    <= 1'b0;
         sync_gap  <= 16'h0000;
         sync_last <= 16'h0000;
         sync_ok   <= 1'b0;
      end else if (ce) begin
         sync_q <= sync_in;
         if (sync_rise) begin
            sync_gap  <= 16'h0000;
            sync_last <= sync_gap;
            if (en_rise || state == mpc_pkg::MPC_OFF)
               sync_ok <= 1'b1;
         end else begin
            if (!sync_lost)
               sync_gap <= sync_gap + 16'h0001;
            if (sync_lost)
               sync_ok <= 1'b0;
         end
      end
   end

   // switching period: sync, last seen, or configured
   wire [15:0] next_period = sync_ok           ? sync_last :
                             sync_last != 16'h0000 ? sync_last :
                                                 freq_cfg;

   // ----------------------------------------------------------------
   // sharing rail bookkeeping
   // ----------------------------------------------------------------
   wire rx_share = bus_rx.valid && bus_rx.kind == `MPC_MSG_SHARE;
   wire rx_flt   = bus_rx.valid && bus_rx.kind == `MPC_MSG_FAULT;
   wire [2:0] rx_slot = bus_rx.addr[2:0];
   wire [3:0] members = count8(alive);
   wire rail_dead = sh_en && (alive & ~failed) == 8'h00 && members != 4'h0;
   wire my_alive = (state == mpc_pkg::MPC_REG || state == mpc_pkg::MPC_RAMP);
   // lowest live address wins the reference role
   wire next_ref = sh_en && my_alive &&
                   (low_seen >= my_addr);

   // track live peers and the lowest live address
   always_ff @(posedge mclk) begin
      if (rst) begin
         alive    <= 8'h00;
         failed   <= 8'h00;
         low_seen <= 7'h7f;
      end else if (ce) begin
         if (!sh_en || en_rise) begin
            alive    <= 8'h00;
            failed   <= 8'h00;
            low_seen <= 7'h7f;
         end else begin
            alive[my_addr[2:0]]  <= my_alive;
            failed[my_addr[2:0]] <= local_fault;
            if (rx_share) begin
               alive[rx_slot]  <= 1'b1;
               failed[rx_slot] <= 1'b0;
               if (bus_rx.addr < low_seen)
                  low_seen <= bus_rx.addr;
            end
            if (rx_flt)
               failed[rx_slot] <= 1'b1;
            if (rx_flt && bus_rx.addr == low_seen)
               low_seen <= 7'h7f;
         end
      end
   end

   // phase offset: address (rank when sharing) times 45, wrapped to three bits
   wire [8:0] addr_phase = 9'({6'h00, my_addr[2:0]} * `MPC_PHASE_STEP);
   wire [8:0] rank_phase = 9'({6'h00, rank} * `MPC_PHASE_STEP);
   wire [8:0] next_phase = phase_cfg[`MPC_PH_OVR_BIT] ? phase_cfg[8:0] :
                           sh_en ? rank_phase : addr_phase;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   wire [31:0] on_wait  = PRE_RAMP_CYC + {16'h0000, delay_cfg[15:0]};
   wire [31:0] off_wait = {16'h0000, delay_cfg[31:16]};
   wire        at_tgt   = out_level == target_level;
   wire [11:0] trk_ref  = trk_half ? {1'b0, tracking_reference_input[11:1]}
                                   : tracking_reference_input;
   wire        own_flt  = local_fault && f_shut &&
                          !(sh_en && sh_qr);
   wire        take_rx  = rx_flt && f_rx && !sh_en;
   wire [11:0] step     = 12'(RAMP_STEP);
   wire [11:0] next_up  = (target_level - out_level > step) ?
                          out_level + step : target_level;
   wire [11:0] next_dn  = (out_level > step) ? out_level - step : 12'h000;
   // tracked level, clipped at target, held once settled unless follow is set
   wire [11:0] trk_lvl  = (trk_ref > target_level) ? target_level : trk_ref;
   wire        trk_upd  = !settled || trk_fol;

   // state and level sequencing
   always_ff @(posedge mclk) begin
      if (rst) begin
         state     <= mpc_pkg::MPC_OFF;
         tmr       <= 32'h0000_0000;
         out_level <= 12'h000;
         out_on    <= 1'b0;
         en_q      <= 1'b0;
         rx_fault  <= 1'b0;
         flt_hold  <= 1'b0;
         settled   <= 1'b0;
      end else if (ce) begin
         en_q <= enable_in;
         if (take_rx)
            rx_fault <= 1'b1;
         else if (state == mpc_pkg::MPC_OFF && en_rise)
            rx_fault <= 1'b0;
         case (state)
            mpc_pkg::MPC_OFF: begin
               out_on <= 1'b0;
               if ((en_rise || (flt_hold && f_rst && enable_in)) &&
                   (pred_done || flt_hold)) begin
                  state    <= mpc_pkg::MPC_DELAY;
                  tmr      <= 32'h0000_0000;
                  flt_hold <= 1'b0;
               end
            end
            mpc_pkg::MPC_DELAY: begin
               tmr <= tmr + 32'h0000_0001;
               if (!enable_in)
                  state <= mpc_pkg::MPC_OFF;
               else if (tmr >= on_wait) begin
                  state   <= mpc_pkg::MPC_RAMP;
                  out_on  <= 1'b1;
                  settled <= 1'b0;
               end
            end
            mpc_pkg::MPC_RAMP: begin
               out_level <= trk_en ? trk_lvl : next_up;
               if (trk_en ? (trk_lvl == target_level) : at_tgt)
                  state <= mpc_pkg::MPC_REG;
               if (!enable_in) begin
                  state <= mpc_pkg::MPC_STOP;
                  tmr   <= 32'h0000_0000;
               end
            end
            mpc_pkg::MPC_REG: begin
               settled <= 1'b1;
               if (trk_en && trk_upd)
                  out_level <= trk_lvl;
               if (!enable_in) begin
                  state <= mpc_pkg::MPC_STOP;
                  tmr   <= 32'h0000_0000;
               end
            end
            mpc_pkg::MPC_STOP: begin
               tmr <= tmr + 32'h0000_0001;
               if (trk_en) begin
                  out_level <= trk_lvl;
                  if (tmr >= off_wait)
                     out_level <= next_dn;
               end else if (tmr >= off_wait)
                  out_level <= next_dn;
               if (tmr >= off_wait && out_level == 12'h000) begin
                  state  <= mpc_pkg::MPC_OFF;
                  out_on <= 1'b0;
               end
            end
            mpc_pkg::MPC_FAULT: begin
               out_on    <= 1'b0;
               out_level <= 12'h000;
               if (!local_fault && !rail_dead) begin
                  state    <= mpc_pkg::MPC_OFF;
                  flt_hold <= 1'b1;
               end
            end
            default: state <= mpc_pkg::MPC_OFF;
         endcase
         if (state != mpc_pkg::MPC_OFF && state != mpc_pkg::MPC_FAULT &&
             (own_flt || take_rx || (sh_en && rail_dead)))
            state <= mpc_pkg::MPC_FAULT;
      end
   end

   // ----------------------------------------------------------------
   // outputs: bus message, reference, phase, recompensation
   // ----------------------------------------------------------------
   wire flt_edge   = own_flt && state != mpc_pkg::MPC_FAULT &&
                     state != mpc_pkg::MPC_OFF;
   wire rail_edge  = rail_dead && !rail_sent;
   wire [1:0] tx_kind = (flt_edge || rail_edge) ? `MPC_MSG_FAULT
                                                : `MPC_MSG_SHARE;
   wire tx_go = ((flt_edge && !sh_en) || rail_edge) && f_tx ||
                (is_reference && my_alive);
   wire next_recomp = ctrl[`MPC_CTL_RCMP_BIT] &&
                      state == mpc_pkg::MPC_RAMP &&
                      (trk_en ? trk_lvl == target_level : at_tgt);
   wire next_afc = ctrl[`MPC_CTL_AFC_BIT] && ctrl[`MPC_CTL_DE_BIT] &&
                   !sh_en && !sync_ok;

   // registered outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_tx       <= '0;
         sync_locked  <= 1'b0;
         sw_period    <= `MPC_FREQ_RST;
         phase_deg    <= 9'h000;
         recomp_pulse <= 1'b0;
         afc_active   <= 1'b0;
         is_reference <= 1'b0;
         share_ref    <= 12'h000;
         rank         <= 3'h0;
         members_q    <= 4'h0;
         rail_sent    <= 1'b0;
      end else if (ce) begin
         bus_tx.valid <= tx_go;
         bus_tx.kind  <= tx_kind;
         bus_tx.addr  <= my_addr;
         bus_tx.data  <= my_current;
         if (rail_edge && f_tx)
            rail_sent <= 1'b1;
         else if (!rail_dead)
            rail_sent <= 1'b0;
         sync_locked  <= sync_ok;
         sw_period    <= next_period;
         members_q    <= members;
         rank         <= 3'(count8(alive & ((8'h01 << my_addr[2:0]) -
                                         8'h01)));
         if (members != members_q)
            phase_deg <= next_phase;
         else
            phase_deg <= next_phase;
         recomp_pulse <= next_recomp;
         afc_active   <= next_afc;
         is_reference <= next_ref;
         if (rx_share && !is_reference)
            share_ref <= bus_rx.data;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_afc_gate: assert property (@(posedge mclk) disable iff (rst)
      afc_active |-> !$past(sh_en) && $past(ctrl[`MPC_CTL_DE_BIT]))
      else $error("adaptive frequency outside allowed mode");
   a_phase_addr: assert property (@(posedge mclk) disable iff (rst)
      ce && !sh_en && !phase_cfg[`MPC_PH_OVR_BIT] && $stable(my_addr)
      |=> !ce || phase_deg == 9'({6'h00, my_addr[2:0]} * 9'h02d))
      else $error("phase not address times 45");
   a_tx_addr: assert property (@(posedge mclk) disable iff (rst)
      bus_tx.valid |-> bus_tx.addr == $past(my_addr))
      else $error("message without sender address");
   a_ramp_wait: assert property (@(posedge mclk) disable iff (rst)
      state == mpc_pkg::MPC_DELAY && $past(state) == mpc_pkg::MPC_OFF
      |-> !out_on)
      else $error("output on before pre-ramp delay");
   a_fault_stop: assert property (@(posedge mclk) disable iff (rst)
      ce && own_flt && state == mpc_pkg::MPC_REG
      |=> !ce || state == mpc_pkg::MPC_FAULT)
      else $error("fault did not shut down");
   a_rx_stop: assert property (@(posedge mclk) disable iff (rst)
      ce && take_rx && state == mpc_pkg::MPC_REG
      |=> !ce || state == mpc_pkg::MPC_FAULT)
      else $error("received fault ignored");
   a_sync_lost: assert property (@(posedge mclk) disable iff (rst)
      ce && sync_ok && sync_lost && !sync_rise |=> !ce || !sync_ok)
      else $error("lost sync not dropped");
   a_track_half: assert property (@(posedge mclk) disable iff (rst)
      ce && state == mpc_pkg::MPC_RAMP && trk_en && trk_half &&
      !own_flt && !take_rx && !rail_dead
      |=> !ce || out_level <= $past(tracking_reference_input) / 2)
      else $error("half-rate tracking too high");
endmodule

/* test/mpc_peer.sv */
// peer power module on the shared bus, sends fault and share messages
`timescale 1ns/1ns
`include "mpc_map.svh"
module mpc_peer (
   input  wire logic         mclk,
   input  wire logic         send_fault,
   input  wire logic         send_share,
   input  wire logic [6:0]   peer_addr,
   input  wire logic [11:0]  peer_cur,
   output mpc_pkg::mpc_msg_s bus_out
);
   logic [11:0] junk = 12'h5a5;
   wire         send = send_fault || send_share;
   // fault or share message; idle fields churn so stale values never match
   always_ff @(posedge mclk) begin
      junk <= ~junk;
      bus_out.valid <= send;
      bus_out.kind <= send_fault ? `MPC_MSG_FAULT :
                      send_share ? `MPC_MSG_SHARE : ~bus_out.kind;
      bus_out.addr <= send ? peer_addr : junk[6:0];
      bus_out.data <= send_share ? peer_cur : junk;
   end
endmodule

/* test/tb.sv */
// self-checking bench for the power coordinator
`timescale 1ns/1ns
`include "mpc_map.svh"
module tb;
   localparam int PRE = 20;
   logic              mclk = 0, rst = 1, ena = 0, sync = 0, flt = 0;
   logic              pfault = 0, sync_run = 0, pred = 0, rd_seen = 0;
   logic              pshare = 0, low = 0;
   logic [11:0]       pcur = '0;
   mpc_pkg::mpc_req_s req = '0;
   mpc_pkg::mpc_msg_s rx, tx;
   logic [31:0]       rdata, seed = 32'h1d;
   logic [6:0]        addr = '0;
   logic [11:0]       trk = '0, tgt = '0, cur = '0, lvl, sref;
   logic [15:0]       per;
   logic [8:0]        ph;
   logic              on, lock, rc, afc, isref;
   logic [63:0]       expq[$];
   logic [63:0]       e;
   logic [3:0]        watch;
   int                n_mismatch = 0, total_checks = 0, cnt, sc = 0;
   assign watch = {rc, tx.valid, on, lock};
   // clock and a 12-cycle sync clock that can be stopped
   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      sc <= (sc == 5) ? 0 : sc + 1;
      if (sync_run && sc == 5) sync <= ~sync;
   end
   mpc_coord #(.PRE_RAMP_CYC(PRE)) mpc_coord_i (.mclk(mclk), .rst(rst),
      .ce(1'h1), .req(req), .rdata(rdata), .enable_in(ena), .sync_in(sync),
      .my_addr(addr), .tracking_reference_input(trk), .target_level(tgt),
      .my_current(cur), .local_fault(flt), .pred_done(pred), .bus_rx(rx),
      .bus_tx(tx), .out_level(lvl), .out_on(on), .sync_locked(lock),
      .sw_period(per), .phase_deg(ph), .recomp_pulse(rc), .afc_active(afc),
      .is_reference(isref), .share_ref(sref));
   mpc_peer mpc_peer_i (.mclk(mclk), .send_fault(pfault),
      .send_share(pshare), .peer_addr(addr ^ 7'h01), .peer_cur(pcur),
      .bus_out(rx));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, got);
      total_checks++;
      if (got !== ex) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic results();
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one bus cycle; a read notes its expected word and mask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, m);
      @(posedge mclk);
      req <= '{w, ~w, a, d};
      if (!w) expq.push_back({m, d});
      @(posedge mclk);
      req <= '0;
   endtask
   task automatic wt(input int s, input logic v, input int lim);
      cnt = 0;
      while (watch[s] !== v && cnt < lim) begin
         @(posedge mclk);
         cnt++;
      end
      if (cnt >= lim) begin
         chk("wait", v, watch[s]);
         results();
      end
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge mclk) begin
      rd_seen <= req.rd;
      if (rd_seen) begin
         e = expq.pop_front();
         chk("rdata", e[31:0], rdata & e[63:32]);
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      void'(rnd());
      rst <= 0;
      addr <= seed[6:0];
      tgt <= {4'h1, seed[15:8]};
      trk <= seed[27:16];
      cur <= seed[31:20];
      bus(0, `MPC_CTRL_OFS, `MPC_CTRL_RST, '1);
      bus(0, `MPC_FAULT_OFS, `MPC_FAULT_RST, '1);
      bus(0, `MPC_FREQ_OFS, 32'h14, '1);
      bus(0, 8'h20, '0, '1);
      bus(0, `MPC_STATUS_OFS, 32'h01, 32'h3f);
      bus(1, `MPC_FREQ_OFS, 32'h30, '0);
      bus(1, `MPC_CTRL_OFS, 32'h07, '0);
      bus(1, `MPC_DELAY_OFS, 32'h05, '0);
      bus(1, `MPC_FAULT_OFS, 32'h03, '0);
      pred <= 1;
      ena <= 1;
      wt(1, 1, 200);
      chk("pre_ramp", 1, cnt >= PRE + 5 && cnt <= PRE + 9);
      chk("period", 32'h30, per);
      chk("afc", 1, afc);
      wt(3, 1, 400);
      @(posedge mclk);
      chk("level", tgt, lvl);
      flt <= 1;
      wt(2, 1, 50);
      chk("tx_kind", `MPC_MSG_FAULT, tx.kind);
      chk("tx_addr", addr, tx.addr);
      wt(1, 0, 50);
      flt <= 0;
      ena <= 0;
      sync_run <= 1;
      repeat (60) @(posedge mclk);
      bus(1, `MPC_FAULT_OFS, 32'h05, '0);
      ena <= 1;
      wt(1, 1, 200);
      wt(0, 1, 100);
      chk("afc", 0, afc);
      chk("phase", 9'(addr[2:0]) * `MPC_PHASE_STEP, ph);
      sync_run <= 0;
      wt(0, 0, 400);
      chk("period", 1, per >= 16'h0b && per <= 16'h0d);
      pfault <= 1;
      @(posedge mclk);
      pfault <= 0;
      wt(1, 0, 50);
      // half-rate tracking of a reference above our target
      ena <= 0;
      trk <= {1'b1, seed[10:0]};
      bus(1, `MPC_TRACK_OFS, 32'h03, '0);
      bus(1, `MPC_DELAY_OFS, 32'h0010_0005, '0);
      ena <= 1;
      wt(1, 1, 200);
      repeat (3) @(posedge mclk);
      chk("track", tgt, lvl);
      trk <= seed[11:0] & 12'h1ff;
      repeat (3) @(posedge mclk);
      chk("track_hold", tgt, lvl);
      ena <= 0;
      repeat (10) @(posedge mclk);
      chk("track_off", trk >> 1, lvl);
      wt(1, 0, 200);
      // sharing rail with one peer, role decided by address
      bus(1, `MPC_TRACK_OFS, 32'h00, '0);
      bus(1, `MPC_SHARE_OFS, 32'h01, '0);
      void'(rnd());
      pcur <= seed[11:0];
      pshare <= 1;
      ena <= 1;
      wt(1, 1, 200);
      repeat (40) @(posedge mclk);
      low = (addr ^ 7'h01) < addr;
      chk("is_ref", !low, isref);
      chk("afc", 0, afc);
      chk("phase", low ? `MPC_PHASE_STEP : 9'h000, ph);
      if (low)
         chk("share_ref", pcur, sref);
      else
         chk("tx_share", {1'b1, `MPC_MSG_SHARE, cur},
             {tx.valid, tx.kind, tx.data});
      pshare <= 0;
      pfault <= 1;
      @(posedge mclk);
      pfault <= 0;
      repeat (4) @(posedge mclk);
      chk("ref_take", 1, isref);
      results();
   end
endmodule
